// ==== cbs_consts.vh ====
// Constants for the system-register access decoder of the group 1 alias / group 0 binary point block
`ifndef CBS_CONSTS_VH
`define CBS_CONSTS_VH

// Coprocessor encodings
`define CBS_COPROC 4'b1111
`define CBS_CRN 4'b1100
`define CBS_AP1_OPC1 3'b000
`define CBS_AP1_CRM 4'b1001
`define CBS_BPR0_CRM 4'b1000
`define CBS_BPR0_OPC2 3'b011
`define CBS_ASGI_OPC1 4'b0001
`define CBS_ASGI_CRM 4'b1100

// Alias SGI register field positions
`define CBS_AFFINITY_LEVEL3_HI 55
`define CBS_AFFINITY_LEVEL3_LO 48
`define CBS_IRM_BIT 40
`define CBS_AFFINITY_LEVEL2_HI 39
`define CBS_AFFINITY_LEVEL2_LO 32
`define CBS_ID_HI 27
`define CBS_ID_LO 24
`define CBS_AFFINITY_LEVEL1_HI 23
`define CBS_AFFINITY_LEVEL1_LO 16
`define CBS_TLIST_HI 15
`define CBS_TLIST_LO 0

// Binary point field
`define CBS_BP_HI 2
`define CBS_BP_LO 0
`define CBS_BP_NOPREEMPT 3'h7

// Exception levels
`define CBS_EL0 2'h0
`define CBS_EL1 2'h1
`define CBS_EL2 2'h2
`define CBS_EL3 2'h3

// Access outcome codes
`define CBS_RES_OK 3'h0
`define CBS_RES_VIRT 3'h1
`define CBS_RES_TRAP_EL2 3'h2
`define CBS_RES_TRAP_EL3 3'h3
`define CBS_RES_UNDEF 3'h4
`define CBS_RES_NONE 3'h5

`endif

// ==== cbs_bp_clamp.v ====
// Group 0 binary point clamp against the minimum value
`include "cbs_consts.vh"

module cbs_bp_clamp
(
  input wire [2:0] i_value,
  input wire [2:0] i_minimum,
  output wire [2:0] o_value
);

  // A value below the minimum is raised to the minimum
  assign o_value = (i_value < i_minimum) ? i_minimum : i_value;

endmodule

// ==== cbs_sysreg_block.v ====
// Group 1 active-priority decode, alias SGI generation and group 0 binary point
`include "cbs_consts.vh"

// Contract
// - Decode active-priority group 1 access: CRm 1001, opc2 = 0 then index.
// - Hyp IRQ routing set: non-secure EL1 active-priority access goes virtual.
// - Alias SGI write requests group 1 SGIs for opposite security state; EL0 refused.
// - Hyp FIQ or IRQ routing set traps non-secure EL1 alias SGI writes to EL2.
// - Hyp common trap set traps non-secure EL1 alias SGI writes to EL2.
// - Class 12 trap set traps non-secure EL1 alias SGI writes to EL2.
// - Monitor FIQ and IRQ set trap secure EL1, EL2 (and unrouted NS EL1) to EL3.
// - Interface enable clear makes EL1 alias SGI writes undefined.
// - Alias SGI register is 64 bits, one instance for both states.
// - Three affinity fields, reserved-zero when routing mode is 1.
// - Routing mode 0 targets affinity path and list; 1 targets all but self.
// - SGI identifier comes from bits 27 to 24.
// - Target list bit n selects affinity-0 number n; zero when routing mode 1.
// - Distributor ignores list bits naming no valid element.
// - Hyp FIQ routing set: non-secure EL1 binary point access goes virtual.
// - Binary point minimum from priority bits; writes clamp up; reset loads minimum.
// - Hyp group 0 trap-all set traps non-secure EL1 binary point access to EL2.
// - Monitor FIQ set with 64-bit EL3 traps secure EL1 and EL2 accesses to EL3.
// - Binary point is 3 bits in 32; upper bits read zero; 7 means no preemption.
module cbs_sysreg_block
#(
  parameter PRIORITY_BIT_COUNT = 5,
  parameter TARGET_COUNT = 16
)
(
  input wire i_clock,
  input wire i_sys_rst,
  // Core access request
  input wire i_req_valid,
  input wire i_req_write,
  input wire i_req_dual,
  input wire [3:0] i_req_coproc,
  input wire [3:0] i_req_opc1,
  input wire [3:0] i_req_crn,
  input wire [3:0] i_req_crm,
  input wire [2:0] i_req_opc2,
  input wire [31:0] i_req_wdata_lo,
  input wire [31:0] i_req_wdata_hi,
  // Core execution state
  input wire [1:0] i_el,
  input wire i_secure,
  input wire i_self_secure_el3_a64,
  // Control bits
  input wire i_hyp_irq_routing,
  input wire i_hyp_fiq_routing,
  input wire i_hyp_common_trap,
  input wire i_hyp_group0_trap_all,
  input wire i_hyp_class12_trap,
  input wire i_monitor_fiq_routing,
  input wire i_monitor_irq_routing,
  input wire i_sysreg_interface_enable,
  // Answer to the core
  output reg o_rsp_valid,
  output reg [2:0] o_rsp_result,
  output reg [31:0] o_rsp_rdata,
  output reg o_ap1_sel,
  output reg [1:0] o_ap1_index,
  output wire [2:0] o_priority_split_point,
  // Generation request to distributor
  output reg o_sgi_valid,
  output reg [3:0] o_sgi_interrupt_identifier,
  output reg o_sgi_routing_mode_bit,
  output reg [7:0] o_sgi_affinity_level3,
  output reg [7:0] o_sgi_affinity_level2,
  output reg [7:0] o_sgi_affinity_level1,
  output reg [15:0] o_sgi_target_pe_list,
  output reg o_sgi_target_secure
);

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  // With N priority bits the lowest useful split point is 7 - N
  localparam [2:0] BP_MINIMUM = 3'd7 - PRIORITY_BIT_COUNT[2:0];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire common_enc;
  wire hit_ap1;
  wire hit_bpr0;
  wire hit_asgi;
  wire ns_el1;
  wire s_el1_or_el2;

  assign common_enc = i_req_coproc == `CBS_COPROC;
  // Active priority group 1: opc2 top bit zero
  assign hit_ap1 = common_enc && !i_req_dual && i_req_crn == `CBS_CRN &&
                   i_req_opc1[2:0] == `CBS_AP1_OPC1 && i_req_crm == `CBS_AP1_CRM &&
                   !i_req_opc2[2];
  assign hit_bpr0 = common_enc && !i_req_dual && i_req_crn == `CBS_CRN &&
                    i_req_opc1[2:0] == `CBS_AP1_OPC1 && i_req_crm == `CBS_BPR0_CRM &&
                    i_req_opc2 == `CBS_BPR0_OPC2;
  // Two-register transfer carries no CRn or opc2
  assign hit_asgi = common_enc && i_req_dual && i_req_opc1 == `CBS_ASGI_OPC1 &&
                    i_req_crm == `CBS_ASGI_CRM && i_req_write;

  assign ns_el1 = !i_secure && i_el == `CBS_EL1;
  assign s_el1_or_el2 = (i_secure && i_el == `CBS_EL1) || i_el == `CBS_EL2;

  // ----------------------------------------------------------------
  // Alias SGI outcome
  // ----------------------------------------------------------------
  reg [2:0] asgi_res;
  always @*
  begin
    asgi_res = `CBS_RES_OK;
    if (i_el == `CBS_EL0)
      asgi_res = `CBS_RES_UNDEF;
    else if (i_el == `CBS_EL1 && !i_sysreg_interface_enable)
      asgi_res = `CBS_RES_UNDEF;
    else if (ns_el1 && (i_hyp_fiq_routing || i_hyp_irq_routing))
      asgi_res = `CBS_RES_TRAP_EL2;
    else if (ns_el1 && i_hyp_common_trap)
      asgi_res = `CBS_RES_TRAP_EL2;
    else if (ns_el1 && i_hyp_class12_trap)
      asgi_res = `CBS_RES_TRAP_EL2;
    else if (i_monitor_fiq_routing && i_monitor_irq_routing && i_el != `CBS_EL3)
      // NS EL1 reaches here only with both hyp routing bits clear
      asgi_res = `CBS_RES_TRAP_EL3;
  end

  // ----------------------------------------------------------------
  // Active priority outcome
  // ----------------------------------------------------------------
  reg [2:0] ap1_res;
  always @*
  begin
    ap1_res = `CBS_RES_OK;
    if (i_el == `CBS_EL0)
      ap1_res = `CBS_RES_UNDEF;
    else if (i_el == `CBS_EL1 && !i_sysreg_interface_enable)
      ap1_res = `CBS_RES_UNDEF;
    else if (ns_el1 && i_hyp_irq_routing)
      ap1_res = `CBS_RES_VIRT;
    else if (ns_el1 && i_hyp_class12_trap)
      ap1_res = `CBS_RES_TRAP_EL2;
  end

  // ----------------------------------------------------------------
  // Binary point outcome
  // ----------------------------------------------------------------
  reg [2:0] bp_res;
  always @*
  begin
    bp_res = `CBS_RES_OK;
    if (i_el == `CBS_EL0)
      bp_res = `CBS_RES_UNDEF;
    else if (i_el == `CBS_EL1 && !i_sysreg_interface_enable)
      bp_res = `CBS_RES_UNDEF;
    else if (ns_el1 && i_hyp_fiq_routing)
      bp_res = `CBS_RES_VIRT;
    else if (ns_el1 && (i_hyp_class12_trap || i_hyp_group0_trap_all))
      bp_res = `CBS_RES_TRAP_EL2;
    else if (i_monitor_fiq_routing && i_self_secure_el3_a64 && s_el1_or_el2)
      bp_res = `CBS_RES_TRAP_EL3;
    else if (i_monitor_fiq_routing && i_self_secure_el3_a64 && ns_el1)
      bp_res = `CBS_RES_TRAP_EL3;
  end

  // ----------------------------------------------------------------
  // Binary point storage
  // ----------------------------------------------------------------
  reg [2:0] bp_q;
  wire [2:0] bp_clamped;

  cbs_bp_clamp u_clamp
  (
    .i_value(i_req_wdata_lo[`CBS_BP_HI:`CBS_BP_LO]),
    .i_minimum(BP_MINIMUM),
    .o_value(bp_clamped)
  );

  // Reset loads the minimum; writes below it are raised
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      bp_q <= BP_MINIMUM;
    else if (i_req_valid && hit_bpr0 && i_req_write && bp_res == `CBS_RES_OK)
      bp_q <= bp_clamped;
  end

  // Value 7 leaves no group priority bits, so nothing preempts
  assign o_priority_split_point = bp_q;

  // ----------------------------------------------------------------
  // Alias SGI field extraction
  // ----------------------------------------------------------------
  // Single 64-bit image, not banked by security state
  wire [63:0] asgi_word = {i_req_wdata_hi, i_req_wdata_lo};
  wire routing_mode_bit = asgi_word[`CBS_IRM_BIT];
  wire [15:0] valid_mask;

  // Only list bits naming a real element reach the distributor
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_mask
      assign valid_mask[g] = (g < TARGET_COUNT) ? 1'b1 : 1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Response and generation request
  // ----------------------------------------------------------------
  // Registered answer one cycle after the request
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_result <= `CBS_RES_NONE;
      o_rsp_rdata <= 32'h0000_0000;
      o_ap1_sel <= 1'b0;
      o_ap1_index <= 2'h0;
      o_sgi_valid <= 1'b0;
      o_sgi_interrupt_identifier <= 4'h0;
      o_sgi_routing_mode_bit <= 1'b0;
      o_sgi_affinity_level3 <= 8'h00;
      o_sgi_affinity_level2 <= 8'h00;
      o_sgi_affinity_level1 <= 8'h00;
      o_sgi_target_pe_list <= 16'h0000;
      o_sgi_target_secure <= 1'b0;
    end
    else
    begin
      o_rsp_valid <= i_req_valid;
      o_rsp_rdata <= 32'h0000_0000;
      o_ap1_sel <= 1'b0;
      o_sgi_valid <= 1'b0;
      if (!i_req_valid)
        o_rsp_result <= `CBS_RES_NONE;
      else if (hit_asgi)
      begin
        o_rsp_result <= asgi_res;
        if (asgi_res == `CBS_RES_OK)
        begin
          o_sgi_valid <= 1'b1;
          o_sgi_target_secure <= ~i_secure;
          o_sgi_interrupt_identifier <= asgi_word[`CBS_ID_HI:`CBS_ID_LO];
          o_sgi_routing_mode_bit <= routing_mode_bit;
          // Affinity and list are meaningless in broadcast mode
          o_sgi_affinity_level3 <= routing_mode_bit ? 8'h00 : asgi_word[`CBS_AFFINITY_LEVEL3_HI:`CBS_AFFINITY_LEVEL3_LO];
          o_sgi_affinity_level2 <= routing_mode_bit ? 8'h00 : asgi_word[`CBS_AFFINITY_LEVEL2_HI:`CBS_AFFINITY_LEVEL2_LO];
          o_sgi_affinity_level1 <= routing_mode_bit ? 8'h00 : asgi_word[`CBS_AFFINITY_LEVEL1_HI:`CBS_AFFINITY_LEVEL1_LO];
          o_sgi_target_pe_list <= routing_mode_bit ? 16'h0000 :
                                  (asgi_word[`CBS_TLIST_HI:`CBS_TLIST_LO] & valid_mask);
        end
      end
      else if (hit_ap1)
      begin
        o_rsp_result <= ap1_res;
        o_ap1_sel <= (ap1_res == `CBS_RES_OK) || (ap1_res == `CBS_RES_VIRT);
        o_ap1_index <= i_req_opc2[1:0];
      end
      else if (hit_bpr0)
      begin
        o_rsp_result <= bp_res;
        // Upper bits read as zero
        if (bp_res == `CBS_RES_OK && !i_req_write)
          o_rsp_rdata <= {29'h0000_0000, bp_q};
      end
      else
        // Not an encoding of this block
        o_rsp_result <= `CBS_RES_NONE;
    end
  end

endmodule

// ==== cbs_sysreg_block_chk.sv ====
// Checker for the sysreg block outcomes and generation requests
`include "cbs_consts.vh"
// --------
// Checker
// --------
module cbs_sysreg_block_chk
#(
  parameter PRIORITY_BIT_COUNT = 5,
  parameter TARGET_COUNT = 16
)
(
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_req_valid,
  input wire i_req_write,
  input wire i_req_dual,
  input wire [3:0] i_req_coproc,
  input wire [3:0] i_req_opc1,
  input wire [3:0] i_req_crm,
  input wire [31:0] i_req_wdata_lo,
  input wire [1:0] i_el,
  input wire i_secure,
  input wire i_sysreg_interface_enable,
  input wire o_rsp_valid,
  input wire [2:0] o_rsp_result,
  input wire [2:0] o_priority_split_point,
  input wire o_sgi_valid,
  input wire [3:0] o_sgi_interrupt_identifier,
  input wire o_sgi_routing_mode_bit,
  input wire [7:0] o_sgi_affinity_level1,
  input wire [15:0] o_sgi_target_pe_list,
  input wire o_sgi_target_secure
);
  timeunit 1ns;
  timeprecision 1ps;
  wire asgi_wr;
  // Alias write seen before any trap decision
  assign asgi_wr = i_req_valid & i_req_write & i_req_dual & (i_req_coproc == `CBS_COPROC)
    & (i_req_opc1 == `CBS_ASGI_OPC1) & (i_req_crm == `CBS_ASGI_CRM);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Write taken, request out on the next edge
  sequence s_take;
    asgi_wr ##1 o_sgi_valid;
  endsequence
  AST_RSP_PULSE: assert property (i_req_valid |=> o_rsp_valid) else $error("no answer");
  AST_RSP_IDLE: assert property (!i_req_valid |=> !o_rsp_valid && !o_sgi_valid) else $error("stray pulse");
  AST_SGI_GATED: assert property (o_sgi_valid |-> o_rsp_result == `CBS_RES_OK && $past(asgi_wr))
    else $error("request without write");
  AST_SRE_UNDEF: assert property (asgi_wr && i_el == `CBS_EL1 && !i_sysreg_interface_enable
    |=> o_rsp_result == `CBS_RES_UNDEF && !o_sgi_valid) else $error("enable ignored");
  AST_EL0_NOSGI: assert property (i_req_valid && i_el == `CBS_EL0 |=> !o_sgi_valid) else $error("el0 request");
  AST_SGI_ID: assert property (s_take |-> o_sgi_interrupt_identifier == $past(i_req_wdata_lo[27:24]))
    else $error("wrong id");
  AST_SGI_SEC: assert property (s_take |-> o_sgi_target_secure == !$past(i_secure)) else $error("wrong state");
  AST_BCAST_ZERO: assert property (o_sgi_valid && o_sgi_routing_mode_bit
    |-> o_sgi_affinity_level1 == 8'h00 && o_sgi_target_pe_list == 16'h0000) else $error("broadcast fields");
  AST_BP_MIN: assert property (o_priority_split_point >= 7 - PRIORITY_BIT_COUNT) else $error("below min");
  AST_BP_HOLD: assert property (!$past(i_req_valid) |-> $stable(o_priority_split_point))
    else $error("split moved");
endmodule

bind cbs_sysreg_block cbs_sysreg_block_chk #(.PRIORITY_BIT_COUNT(PRIORITY_BIT_COUNT), .TARGET_COUNT(TARGET_COUNT))
  u_chk (.i_clock, .i_sys_rst, .i_req_valid, .i_req_write, .i_req_dual, .i_req_coproc, .i_req_opc1, .i_req_crm,
  .i_req_wdata_lo, .i_el, .i_secure, .i_sysreg_interface_enable, .o_rsp_valid, .o_rsp_result,
  .o_priority_split_point, .o_sgi_valid, .o_sgi_interrupt_identifier, .o_sgi_routing_mode_bit,
  .o_sgi_affinity_level1, .o_sgi_target_pe_list, .o_sgi_target_secure);

// ==== cbs_dist_model.sv ====
// Distributor stand-in that takes generation requests
module cbs_dist_model
#(
  parameter TARGET_COUNT = 16
)
(
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_valid,
  input wire [15:0] i_list,
  output logic [31:0] o_req_count,
  output logic [15:0] o_valid_list
);
  timeunit 1ns;
  timeprecision 1ps;
  // Count requests; list bits past the last element are dropped
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_req_count <= 32'h0000_0000;
      o_valid_list <= 16'h0000;
    end
    else if (i_valid)
    begin
      o_req_count <= o_req_count + 32'h0000_0001;
      o_valid_list <= i_list & 16'((17'h1_0000 >> (16 - TARGET_COUNT)) - 1);
    end
  end
endmodule

// ==== cbs_sysreg_block_tb.sv ====
// Testbench for the sysreg block
`include "cbs_consts.vh"
module cbs_sysreg_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [2:0] BP_MIN = 3'h2;
  localparam [63:0] D = 64'h0012_0034_0956_8181;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic rv = 1'b0, rw = 1'b0, rd = 1'b0, sec = 1'b0;
  logic [3:0] cp = 4'h0, o1 = 4'h0, cm = 4'h0;
  logic [2:0] o2 = 3'h0, res, split, tgt;
  logic [63:0] wd = 64'h0;
  logic [1:0] el = 2'h0, ap_idx;
  logic [8:0] ct = 9'h000;
  logic rsp_v, ap_sel, sgi_v, srm, tsec;
  logic [31:0] rdata, dcount;
  logic [3:0] sid;
  logic [7:0] a3, a2, a1;
  logic [15:0] tl, dlist;
  int fail_count = 0;
  int samples_checked = 0;
  // --------
  // Design and distributor
  // --------
  cbs_sysreg_block #(.PRIORITY_BIT_COUNT(5), .TARGET_COUNT(8)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_req_valid(rv), .i_req_write(rw), .i_req_dual(rd), .i_req_coproc(cp), .i_req_opc1(o1),
    .i_req_crn(`CBS_CRN), .i_req_crm(cm), .i_req_opc2(o2), .i_req_wdata_lo(wd[31:0]), .i_req_wdata_hi(wd[63:32]),
    .i_el(el), .i_secure(sec), .i_self_secure_el3_a64(ct[7]), .i_hyp_irq_routing(ct[0]),
    .i_hyp_fiq_routing(ct[1]), .i_hyp_common_trap(ct[2]), .i_hyp_group0_trap_all(ct[3]),
    .i_hyp_class12_trap(ct[4]), .i_monitor_fiq_routing(ct[5]), .i_monitor_irq_routing(ct[6]),
    .i_sysreg_interface_enable(ct[8]), .o_rsp_valid(rsp_v), .o_rsp_result(res), .o_rsp_rdata(rdata),
    .o_ap1_sel(ap_sel), .o_ap1_index(ap_idx), .o_priority_split_point(split), .o_sgi_valid(sgi_v),
    .o_sgi_interrupt_identifier(sid), .o_sgi_routing_mode_bit(srm), .o_sgi_affinity_level3(a3),
    .o_sgi_affinity_level2(a2), .o_sgi_affinity_level1(a1), .o_sgi_target_pe_list(tl), .o_sgi_target_secure(tsec));
  cbs_dist_model #(.TARGET_COUNT(8)) u_dist (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_valid(sgi_v),
    .i_list(tl), .o_req_count(dcount), .o_valid_list(dlist));
  // Free-running clock
  always #12.5 i_clock = ~i_clock;
  // Compare and count
  task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One access, kind 0 alias write, 1 binary point, 2 active priority
  task acc(input [1:0] k, input w, input [1:0] l, input s, input [8:0] c, input [63:0] d, input [2:0] exp);
    @(posedge i_clock);
    rv <= 1'b1;
    rw <= w;
    rd <= (k == 0);
    cp <= `CBS_COPROC;
    o1 <= (k == 0) ? `CBS_ASGI_OPC1 : 4'h0;
    cm <= (k == 0) ? `CBS_ASGI_CRM : (k == 1) ? `CBS_BPR0_CRM : `CBS_AP1_CRM;
    o2 <= (k == 1) ? `CBS_BPR0_OPC2 : {1'b0, d[1:0]};
    wd <= d;
    el <= l;
    sec <= s;
    ct <= c;
    @(posedge i_clock);
    rv <= 1'b0;
    #1;
    chk("rsp_valid", rsp_v, 1);
    chk("result", res, exp);
    chk("sgi_valid", sgi_v, (k == 0) && (exp == 0));
  endtask
  // Verdict, reached from the tests and the watchdog
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the forty-four cycles the tests need
  initial
  begin
    repeat (1000) @(posedge i_clock);
    fail_count++;
    tally_and_finish;
  end
  // --------
  // Tests
  // --------
  initial
  begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    chk("split_reset", split, BP_MIN);
    acc(1, 1, 1, 1, 9'h100, 64'h0, 0);
    chk("split_clamp", split, BP_MIN);
    acc(1, 1, 1, 1, 9'h100, 64'hFFFF_FFFE, 0);
    chk("split_six", split, 3'h6);
    acc(1, 0, 2, 0, 9'h100, 64'h0, 0);
    chk("bp_rdata", rdata, 32'h0000_0006);
    acc(1, 1, 1, 0, 9'h102, 64'h7, 1);
    acc(1, 1, 1, 0, 9'h108, 64'h7, 2);
    acc(1, 1, 1, 1, 9'h1A0, 64'h7, 3);
    chk("split_kept", split, 3'h6);
    acc(2, 0, 1, 1, 9'h100, 64'h2, 0);
    chk("ap1", {ap_sel, ap_idx}, 3'h6);
    acc(2, 1, 1, 0, 9'h101, 64'h1, 1);
    chk("ap1_virt", {ap_sel, ap_idx}, 3'h5);
    acc(0, 1, 1, 1, 9'h100, D, 0);
    chk("sgi_fields", {sid, srm, a3, a2, a1, tl, tsec}, {4'h9, 1'b0, 8'h12, 8'h34, 8'h56, 16'h0081, 1'b0});
    // Distributor latches the request one edge after the pulse
    @(posedge i_clock);
    #1;
    chk("dist_list", dlist, 16'h0081);
    acc(0, 1, 2, 0, 9'h100, D | 64'h0000_0100_0000_0000, 0);
    chk("bcast", {srm, a3, a2, a1, tl, tsec}, 42'h200_0000_0001);
    acc(0, 1, 1, 0, 9'h101, D, 2);
    acc(0, 1, 1, 0, 9'h102, D, 2);
    acc(0, 1, 1, 0, 9'h104, D, 2);
    acc(0, 1, 1, 0, 9'h110, D, 2);
    acc(0, 1, 1, 0, 9'h160, D, 3);
    acc(0, 1, 1, 1, 9'h160, D, 3);
    acc(0, 1, 2, 0, 9'h160, D, 3);
    acc(0, 1, 1, 1, 9'h000, D, 4);
    acc(0, 1, 0, 1, 9'h100, D, 4);
    acc(0, 0, 1, 1, 9'h100, D, 5);
    chk("dist_count", dcount, 32'h0000_0002);
    tally_and_finish;
  end
endmodule
